// [hdl/ebt_pkg.sv]
`default_nettype none
package ebt_pkg;
	// register offsets
	localparam logic [11:0] OFS_MODE  = 12'h000;
	localparam logic [11:0] OFS_AREA0 = 12'h010;
	localparam logic [11:0] OFS_AREA1 = 12'h014;
	localparam logic [11:0] OFS_CSC0  = 12'h040;
	localparam logic [11:0] OFS_CSC1  = 12'h044;

	// reset values and writable bits
	localparam logic [31:0] MODE_RST  = 32'h0000_0000;
	localparam logic [31:0] AREA_RST  = 32'h0000_0000;
	localparam logic [31:0] CSC_RST   = 32'h4911_0000;
	localparam logic [31:0] MODE_WMSK = 32'h0000_0007;
	localparam logic [31:0] AREA_WMSK = 32'hFFFF_00FF;
	localparam logic [31:0] CSC_WMSK  = 32'hFF3F_001F;

	// bus_mode_control fields
	localparam int MODE_SEL_BIT = 0;
	localparam int STRETCH_LSB  = 1;

	// area_start_config fields
	localparam int AREA_START_LSB = 16;
	localparam int AREA_SIZE_LSB  = 0;

	// select_timing_control fields
	localparam int SEL_REC_LSB   = 30;
	localparam int WR_REC_LSB    = 27;
	localparam int RD_REC_LSB    = 24;
	localparam int LATCH_DLY_LSB = 20;
	localparam int WR_SETUP_LSB  = 18;
	localparam int RD_SETUP_LSB  = 16;
	localparam int WAIT_LSB      = 0;

	// external window, address bits 31:25
	localparam logic [6:0] EXT_WINDOW = 7'h30;

	// counters and fixed field limits
	localparam int         CNT_W     = 7;
	localparam logic [4:0] WAIT_MAX  = 5'h0F;
	localparam logic [3:0] SIZE_MAX  = 4'h8;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ALE  = 5'b00010,
		ST_ADDR = 5'b00100,
		ST_STRB = 5'b01000,
		ST_DONE = 5'b10000
	} ebt_state_t;
endpackage
`default_nettype wire

// [hdl/ebt_chan_if.sv]
`default_nettype none
interface ebt_chan_if;
	import ebt_pkg::*;
	logic [31:0]      area_cfg;
	logic [31:0]      csc_cfg;
	logic [1:0]       stretch;
	logic [31:0]      addr;
	logic             hit;
	logic [CNT_W-1:0] setup_rd;
	logic [CNT_W-1:0] setup_wr;
	logic [CNT_W-1:0] wait_cnt;
	logic [CNT_W-1:0] latch_clks;
	logic [CNT_W-1:0] rec_rd;
	logic [CNT_W-1:0] rec_wr;

	modport dec (input area_cfg, csc_cfg, stretch, addr,
		output hit, setup_rd, setup_wr, wait_cnt, latch_clks, rec_rd, rec_wr);
	modport ctl (output area_cfg, csc_cfg, stretch, addr,
		input hit, setup_rd, setup_wr, wait_cnt, latch_clks, rec_rd, rec_wr);
endinterface
`default_nettype wire

// [hdl/ebt_chan_decode.sv]
`default_nettype none
module ebt_chan_decode
	import ebt_pkg::*;
(
	ebt_chan_if.dec ch
);
	logic [1:0]       shift;
	logic [3:0]       size_code;
	logic [7:0]       start_mask;
	logic [CNT_W-1:0] sel_rec;

	function automatic logic [CNT_W-1:0] setup_clks(input logic [1:0] code);
		case (code)
			2'b00: setup_clks = 7'h00;
			2'b01: setup_clks = 7'h01;
			2'b10: setup_clks = 7'h02;
			default: setup_clks = 7'h04;
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] rec_clks(input logic [2:0] code);
		rec_clks = (code == 3'h7) ? 7'h08 : {4'h0, code};
	endfunction

	// stretch code 11 is prohibited and behaves as no stretch
	assign shift = (ch.stretch == 2'b01) ? 2'h1 : (ch.stretch == 2'b10) ? 2'h2 : 2'h0;

	// prohibited size codes fall back to the smallest area
	assign size_code  = (ch.area_cfg[AREA_SIZE_LSB +: 8] > {4'h0, SIZE_MAX}) ? SIZE_MAX
		: ch.area_cfg[AREA_SIZE_LSB +: 4];
	assign start_mask = ~(8'hFF >> size_code);
	assign ch.hit     = (ch.addr[31:25] == EXT_WINDOW)
		&& ((ch.addr[23:16] & start_mask) == (ch.area_cfg[AREA_START_LSB +: 8] & start_mask));

	assign ch.wait_cnt = ((ch.csc_cfg[WAIT_LSB +: 5] > WAIT_MAX) ? {2'h0, WAIT_MAX}
		: {2'h0, ch.csc_cfg[WAIT_LSB +: 5]}) << shift;
	assign ch.setup_rd = setup_clks(ch.csc_cfg[RD_SETUP_LSB +: 2]) << shift;
	assign ch.setup_wr = setup_clks(ch.csc_cfg[WR_SETUP_LSB +: 2]) << shift;
	// latch delay 1, 2 or 4
	assign ch.latch_clks = ((ch.csc_cfg[LATCH_DLY_LSB +: 2] == 2'b00) ? 7'h01
		: (ch.csc_cfg[LATCH_DLY_LSB +: 2] == 2'b01) ? 7'h02 : 7'h04) << shift;
	// select recovery 0, 1, 2, 4
	assign sel_rec = setup_clks(ch.csc_cfg[SEL_REC_LSB +: 2]);
	assign ch.rec_rd = CNT_W'((rec_clks(ch.csc_cfg[RD_REC_LSB +: 3]) + sel_rec) << shift);
	assign ch.rec_wr = CNT_W'((rec_clks(ch.csc_cfg[WR_REC_LSB +: 3]) + sel_rec) << shift);
endmodule // ebt_chan_decode
`default_nettype wire

// [hdl/ebt_bus_seq.sv]
`default_nettype none
// Summary of operation
// - separate mode basic external cycle lasts three clocks
// - bus cycle runs on the system clock, no divided bus clock
// - internal access: address held, data floated, strobes idle
// - multiplexed mode basic external cycle lasts four clocks
// - multiplexed internal access: no latch pulse, lines floated, strobes idle
// - per channel wait count 0 to 15 clocks inserted in each access
// - per channel read and write recovery: none, 1 to 6, or 8
// - per channel select recovery: none, 1, 2 or 4 clocks
// - recovery applies between consecutive external accesses
// - per channel read and write setup up to 4 clocks before strobe
// - multiplexed address to strobe delay 1, 2 or 4 clocks
// - latch delay defaults to 2 clocks after reset
// - multiplexed: A23..16 dedicated, 15..0 shared address and data
// - mode bit 1 selects separate, 0 multiplexed
// - stretch field doubles or quadruples setup, wait, recovery
// - channel 0 wins when both channels decode the address
module ebt_bus_seq
	import ebt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_rd_valid,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [31:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic [1:0]  req_byte_en,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic      [15:0] rsp_rdata,
	output logic      [23:0] ext_addr,
	output logic      [15:0] ext_data_out,
	output logic             ext_data_oe_n,
	input  wire logic [15:0] ext_data_in,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	output logic             chip_select_first_n,
	output logic             chip_select_second_n,
	output logic             low_byte_enable_n,
	output logic             high_byte_enable_n,
	output logic             address_latch,
	output logic             bus_mode_separate
);
	ebt_chan_if ch0 ();
	ebt_chan_if ch1 ();
	ebt_chan_decode u_dec0 (.ch(ch0));
	ebt_chan_decode u_dec1 (.ch(ch1));

	// registers
	logic [2:0]  mode_r, mode_nxt;
	logic [31:0] area0_r, area0_nxt, area1_r, area1_nxt;
	logic [31:0] csc0_r, csc0_nxt, csc1_r, csc1_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        rdv_r, rdv_nxt;
	// sequencer
	ebt_state_t       state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, rec_r, rec_nxt;
	logic             sel_r, sel_nxt, wr_r, wr_nxt;
	logic [23:0]      addr_r, addr_nxt;
	logic [15:0]      wdata_r, wdata_nxt, dout_r, dout_nxt;
	logic [1:0]       be_r, be_nxt;
	logic             rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, oe_n_r, oe_n_nxt;
	logic             cs0_n_r, cs0_n_nxt, cs1_n_r, cs1_n_nxt, ale_r, ale_nxt;
	logic             ben_l_r, ben_l_nxt, ben_h_r, ben_h_nxt;
	// answers and pin sampling
	logic             done_d_r, done_d_nxt, rsp_v_r, rsp_v_nxt;
	logic [15:0]      rsp_d_r, rsp_d_nxt, din_s1_r, din_s2_r;
	logic             sep, ext_hit, accept, busy_nxt, drv_addr, drv_data;
	logic [CNT_W-1:0] acc_setup, cur_wait, cur_rec;

	assign ch0.area_cfg = area0_r;
	assign ch0.csc_cfg  = csc0_r;
	assign ch0.stretch  = mode_r[STRETCH_LSB +: 2];
	assign ch0.addr     = req_addr;
	assign ch1.area_cfg = area1_r;
	assign ch1.csc_cfg  = csc1_r;
	assign ch1.stretch  = mode_r[STRETCH_LSB +: 2];
	assign ch1.addr     = req_addr;

	assign sep     = mode_r[MODE_SEL_BIT];
	assign ext_hit = ch0.hit | ch1.hit;
	assign req_ready = (state_r == ST_IDLE) && (!ext_hit || rec_r == '0);
	assign accept    = req_valid && req_ready;
	assign acc_setup = ch0.hit ? (req_write ? ch0.setup_wr : ch0.setup_rd)
		: (req_write ? ch1.setup_wr : ch1.setup_rd);
	assign cur_wait  = sel_r ? ch1.wait_cnt : ch0.wait_cnt;
	assign cur_rec   = sel_r ? (wr_r ? ch1.rec_wr : ch1.rec_rd) : (wr_r ? ch0.rec_wr : ch0.rec_rd);

	// register file, word access only
	always_comb begin
		mode_nxt  = mode_r;
		area0_nxt = area0_r;
		area1_nxt = area1_r;
		csc0_nxt  = csc0_r;
		csc1_nxt  = csc1_r;
		rdata_nxt = rdata_r;
		rdv_nxt   = reg_rd_en;
		if (reg_wr_en) begin
			case (reg_addr)
				OFS_MODE:  mode_nxt  = reg_wdata[2:0] & MODE_WMSK[2:0];
				OFS_AREA0: area0_nxt = reg_wdata & AREA_WMSK;
				OFS_AREA1: area1_nxt = reg_wdata & AREA_WMSK;
				OFS_CSC0:  csc0_nxt  = reg_wdata & CSC_WMSK;
				OFS_CSC1:  csc1_nxt  = reg_wdata & CSC_WMSK;
				default: ;
			endcase
		end
		if (reg_rd_en) begin
			case (reg_addr)
				OFS_MODE:  rdata_nxt = {29'h0, mode_r};
				OFS_AREA0: rdata_nxt = area0_r;
				OFS_AREA1: rdata_nxt = area1_r;
				OFS_CSC0:  rdata_nxt = csc0_r;
				OFS_CSC1:  rdata_nxt = csc1_r;
				default:   rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r  <= MODE_RST[2:0];
			area0_r <= AREA_RST;
			area1_r <= AREA_RST;
			csc0_r  <= CSC_RST;
			csc1_r  <= CSC_RST;
			rdata_r <= 32'h0000_0000;
			rdv_r   <= 1'b0;
		end else begin
			mode_r  <= mode_nxt;
			area0_r <= area0_nxt;
			area1_r <= area1_nxt;
			csc0_r  <= csc0_nxt;
			csc1_r  <= csc1_nxt;
			rdata_r <= rdata_nxt;
			rdv_r   <= rdv_nxt;
		end
	end

	// sequencer: one state per phase, counter stretches each phase except ST_DONE
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		sel_nxt   = sel_r;
		wr_nxt    = wr_r;
		addr_nxt  = addr_r;
		wdata_nxt = wdata_r;
		be_nxt    = be_r;
		rec_nxt   = (rec_r != '0) ? rec_r - 1'b1 : rec_r;
		case (state_r)
			ST_IDLE: begin
				// internal access leaves the bus untouched
				if (accept && ext_hit) begin
					sel_nxt   = !ch0.hit;
					wr_nxt    = req_write;
					addr_nxt  = req_addr[23:0];
					wdata_nxt = req_wdata;
					be_nxt    = req_byte_en;
					state_nxt = sep ? ST_ADDR : ST_ALE;
					cnt_nxt   = sep ? acc_setup : (ch0.hit ? ch0.latch_clks : ch1.latch_clks) - 1'b1;
				end
			end
			ST_ALE: begin
				if (cnt_r == '0) begin
					state_nxt = ST_ADDR;
					cnt_nxt   = sel_r ? (wr_r ? ch1.setup_wr : ch1.setup_rd)
						: (wr_r ? ch0.setup_wr : ch0.setup_rd);
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_ADDR: begin
				if (cnt_r == '0) begin
					state_nxt = ST_STRB;
					cnt_nxt   = cur_wait;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_STRB: begin
				if (cnt_r == '0) begin
					state_nxt = ST_DONE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			// load recovery after the strobe ends
			ST_DONE: begin
				state_nxt = ST_IDLE;
				rec_nxt   = cur_rec;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// pins follow the next state so they change on the phase edge
	always_comb begin
		busy_nxt  = (state_nxt != ST_IDLE);
		// low address half shares the data lines
		drv_addr  = !sep && (state_nxt == ST_ALE || state_nxt == ST_ADDR);
		drv_data  = wr_nxt && (state_nxt == ST_STRB || state_nxt == ST_DONE
			|| (sep && state_nxt == ST_ADDR));
		dout_nxt  = drv_addr ? addr_nxt[15:0] : wdata_nxt;
		oe_n_nxt  = !(drv_addr || drv_data);
		ale_nxt   = (state_nxt == ST_ALE);
		rd_n_nxt  = !(state_nxt == ST_STRB && !wr_nxt);
		wr_n_nxt  = !(state_nxt == ST_STRB && wr_nxt);
		cs0_n_nxt = !(busy_nxt && !sel_nxt);
		cs1_n_nxt = !(busy_nxt && sel_nxt);
		ben_l_nxt = !(busy_nxt && be_nxt[0]);
		ben_h_nxt = !(busy_nxt && be_nxt[1]);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
			rec_r   <= '0;
			sel_r   <= 1'b0;
			wr_r    <= 1'b0;
			addr_r  <= 24'h00_0000;
			wdata_r <= 16'h0000;
			be_r    <= 2'h0;
			dout_r  <= 16'h0000;
			oe_n_r  <= 1'b1;
			ale_r   <= 1'b0;
			rd_n_r  <= 1'b1;
			wr_n_r  <= 1'b1;
			cs0_n_r <= 1'b1;
			cs1_n_r <= 1'b1;
			ben_l_r <= 1'b1;
			ben_h_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			rec_r   <= rec_nxt;
			sel_r   <= sel_nxt;
			wr_r    <= wr_nxt;
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			be_r    <= be_nxt;
			dout_r  <= dout_nxt;
			oe_n_r  <= oe_n_nxt;
			ale_r   <= ale_nxt;
			rd_n_r  <= rd_n_nxt;
			wr_n_r  <= wr_n_nxt;
			cs0_n_r <= cs0_n_nxt;
			cs1_n_r <= cs1_n_nxt;
			ben_l_r <= ben_l_nxt;
			ben_h_r <= ben_h_nxt;
		end
	end

	// read data passes two flops, so the answer trails the cycle by two clocks
	always_comb begin
		done_d_nxt = (state_r == ST_DONE);
		rsp_v_nxt  = done_d_r || (accept && !ext_hit);
		rsp_d_nxt  = done_d_r ? (wr_r ? 16'h0000 : din_s2_r) : 16'h0000;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_d_r <= 1'b0;
			rsp_v_r  <= 1'b0;
			rsp_d_r  <= 16'h0000;
			din_s1_r <= 16'h0000;
			din_s2_r <= 16'h0000;
		end else begin
			done_d_r <= done_d_nxt;
			rsp_v_r  <= rsp_v_nxt;
			rsp_d_r  <= rsp_d_nxt;
			din_s1_r <= ext_data_in;
			din_s2_r <= din_s1_r;
		end
	end

	assign reg_rdata            = rdata_r;
	assign reg_rd_valid         = rdv_r;
	assign rsp_valid            = rsp_v_r;
	assign rsp_rdata            = rsp_d_r;
	assign ext_addr             = addr_r;
	assign ext_data_out         = dout_r;
	assign ext_data_oe_n        = oe_n_r;
	assign read_strobe_n        = rd_n_r;
	assign write_strobe_n       = wr_n_r;
	assign chip_select_first_n  = cs0_n_r;
	assign chip_select_second_n = cs1_n_r;
	assign low_byte_enable_n    = ben_l_r;
	assign high_byte_enable_n   = ben_h_r;
	assign address_latch        = ale_r;
	assign bus_mode_separate    = sep;

	// checking helpers: cycle length and recovery gap
	logic [7:0] cyc_r, exp_r, gap_r, last_rec_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			cyc_r      <= 8'h00;
			exp_r      <= 8'h00;
			gap_r      <= 8'hFF;
			last_rec_r <= 8'h00;
		end else begin
			cyc_r      <= (accept && ext_hit) ? 8'h01 : cyc_r + 8'h01;
			if (accept && ext_hit) begin
				exp_r <= 8'(acc_setup) + 8'(ch0.hit ? ch0.wait_cnt : ch1.wait_cnt) + 8'h03
					+ (sep ? 8'h00 : 8'(ch0.hit ? ch0.latch_clks : ch1.latch_clks));
			end
			gap_r      <= (state_r == ST_DONE) ? 8'h00 : ((gap_r == 8'hFF) ? gap_r : gap_r + 8'h01);
			if (state_r == ST_DONE) begin
				last_rec_r <= 8'(cur_rec);
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_sep_base_len: assert property ((state_r == ST_DONE && sep && exp_r == 8'h03)
		|-> cyc_r == 8'h03)
		else $error("separate basic cycle not three clocks");
	chk_mux_base_len: assert property ((state_r == ST_DONE && !sep && exp_r == 8'h04)
		|-> cyc_r == 8'h04)
		else $error("multiplexed basic cycle not four clocks");
	chk_cycle_len: assert property (state_r == ST_DONE |-> cyc_r == exp_r)
		else $error("external cycle length differs from setting");
	chk_strobe_on_clk: assert property ((state_r == ST_ADDR && cnt_r == '0)
		|=> (!read_strobe_n || !write_strobe_n))
		else $error("strobe not asserted on the next system clock");
	chk_internal_quiet: assert property ((accept && !ext_hit && state_r == ST_IDLE)
		|=> (read_strobe_n && write_strobe_n && ext_data_oe_n && !address_latch
		&& $stable(ext_addr) && rsp_valid))
		else $error("internal access disturbed the bus");
	chk_recovery_gap: assert property ((accept && ext_hit && gap_r != 8'hFF)
		|-> gap_r >= last_rec_r)
		else $error("external access started inside recovery");
	chk_wait_hold: assert property ((state_r == ST_STRB && cnt_r != '0)
		|=> ($stable(ext_addr) && $stable(read_strobe_n) && $stable(write_strobe_n)
		&& $stable(chip_select_first_n) && $stable(chip_select_second_n)))
		else $error("bus changed during wait");
	chk_ch0_priority: assert property ((accept && ch0.hit && ch1.hit)
		|=> (!chip_select_first_n && chip_select_second_n))
		else $error("channel 0 lost priority");
	chk_mux_address: assert property ((address_latch && !sep)
		|-> (!ext_data_oe_n && ext_data_out == ext_addr[15:0]))
		else $error("shared lines lack address during latch");
	chk_latch_default: assert property ($fell(rst)
		|-> ch0.latch_clks == 7'h02 || mode_r != MODE_RST[2:0])
		else $error("latch delay default not two clocks");
endmodule // ebt_bus_seq
`default_nettype wire

// [hdl/ebt_pkg_unused_guard.sv]
`default_nettype none
`default_nettype wire

// [tb/ebt_mem_model.sv]
`default_nettype none
// asynchronous 16-bit memory on the far side of the pins
module ebt_mem_model (
	input  wire logic        clk,
	input  wire logic [23:0] ext_addr,
	input  wire logic [15:0] ext_data_out,
	output logic      [15:0] ext_data_in,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic        chip_select_first_n,
	input  wire logic        chip_select_second_n,
	input  wire logic        low_byte_enable_n,
	input  wire logic        high_byte_enable_n,
	input  wire logic        address_latch,
	input  wire logic        bus_mode_separate
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	logic [23:0] lat;
	logic [15:0] last = 16'h5A5A;
	logic [3:0]  idx;
	logic        sel;
	assign sel = !(chip_select_first_n && chip_select_second_n);
	// shared lines carry the low address first
	assign idx = bus_mode_separate ? ext_addr[3:0] : lat[3:0];
	// released lines show the inverse of the last value, never a stale copy
	assign ext_data_in = (sel && !read_strobe_n) ? mem[idx] : ~last;
	always @(posedge clk) begin
		if (address_latch)
			lat <= {ext_addr[23:16], ext_data_out};
		if (sel && !read_strobe_n)
			last <= mem[idx];
		if (sel && !write_strobe_n && !low_byte_enable_n)
			mem[idx][7:0] <= ext_data_out[7:0];
		if (sel && !write_strobe_n && !high_byte_enable_n)
			mem[idx][15:8] <= ext_data_out[15:8];
	end
endmodule // ebt_mem_model
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb
	import ebt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A0 = 32'h6000_0002;
	localparam logic [31:0] AM = 32'h6012_3456;
	localparam logic [31:0] AI = 32'h2000_0000;
	logic        clk = 1'h0, rst = 1'h1, reg_wr_en = 1'h0, reg_rd_en = 1'h0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, req_addr = 32'h0, reg_rdata;
	logic        req_valid = 1'h0, req_write = 1'h0, mux = 1'h0, bad;
	logic [15:0] req_wdata = 16'h0, rsp_rdata, ext_data_out, ext_data_in, rd;
	logic [23:0] ext_addr;
	logic [1:0]  cs;
	logic        reg_rd_valid, req_ready, rsp_valid, ext_data_oe_n, read_strobe_n;
	logic        write_strobe_n, chip_select_first_n, chip_select_second_n;
	logic        low_byte_enable_n, high_byte_enable_n, address_latch, bus_mode_separate;
	int          n_errors = 0, tests_run = 0, cyc = 0, n_lat, n_strb, n_ale, n_oe;
	logic [11:0] ofs [7] = '{OFS_MODE, OFS_AREA0, OFS_AREA1, OFS_CSC0, OFS_CSC1, 12'h004, 12'h048};
	logic [31:0] rv [7] = '{MODE_RST, AREA_RST, AREA_RST, CSC_RST, CSC_RST, 32'h0, 32'h0};
	logic [31:0] msk [7] = '{MODE_WMSK, AREA_WMSK, AREA_WMSK, CSC_WMSK, CSC_WMSK, 32'h0, 32'h0};
	int          wv [4] = '{0, 1, 5, 15};

	ebt_bus_seq i_dut (.clk(clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(2'h3), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_addr(ext_addr),
		.ext_data_out(ext_data_out), .ext_data_oe_n(ext_data_oe_n), .ext_data_in(ext_data_in),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.chip_select_first_n(chip_select_first_n), .chip_select_second_n(chip_select_second_n),
		.low_byte_enable_n(low_byte_enable_n), .high_byte_enable_n(high_byte_enable_n),
		.address_latch(address_latch), .bus_mode_separate(bus_mode_separate));

	ebt_mem_model i_mem (.clk(clk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
		.ext_data_in(ext_data_in), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .chip_select_first_n(chip_select_first_n),
		.chip_select_second_n(chip_select_second_n), .low_byte_enable_n(low_byte_enable_n),
		.high_byte_enable_n(high_byte_enable_n), .address_latch(address_latch),
		.bus_mode_separate(bus_mode_separate));

	// one clock times both logic and pins
	always #2.5 clk = ~clk;

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, runs take well under this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr_en <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr_en <= 1'h0;
	endtask

	task automatic reg_check(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd_en <= 1'h1;
		reg_addr  <= a;
		@(posedge clk);
		reg_rd_en <= 1'h0;
		@(negedge clk);
		check(32'(reg_rd_valid), 32'h1); // read answered
		check(reg_rdata, exp); // word read
	endtask

	// returns on the accepting edge; n counts the cycles waited
	task automatic wait_ready(output int n);
		int k;
		for (k = 1; k < 100; k++) begin
			@(negedge clk);
			if (req_ready === 1'h1)
				break;
		end
		n = k;
		@(posedge clk);
	endtask

	task automatic access(input logic wr, input logic [31:0] a, input logic [15:0] d);
		int k;
		@(posedge clk);
		req_valid <= 1'h1;
		req_write <= wr;
		req_addr  <= a;
		req_wdata <= d;
		wait_ready(k);
		req_valid <= 1'h0;
		n_strb = 0;
		n_ale = 0;
		n_oe = 0;
		cs = 2'h0;
		bad = 1'h0;
		for (k = 1; k < 200; k++) begin
			@(negedge clk);
			// pins steady while a strobe is held
			if (!read_strobe_n || !write_strobe_n) begin
				n_strb++;
				bad |= mux ? ext_addr[23:16] !== a[23:16] : ext_addr !== a[23:0];
				bad |= !write_strobe_n && (ext_data_out !== d || ext_data_oe_n !== 1'h0);
				bad |= !read_strobe_n && ext_data_oe_n !== 1'h1;
				bad |= {high_byte_enable_n, low_byte_enable_n} !== 2'h0;
			end
			if (address_latch === 1'h1) begin
				n_ale++;
				bad |= ext_data_out !== a[15:0] || ext_addr[23:16] !== a[23:16];
			end
			n_oe += int'(ext_data_oe_n === 1'h0);
			cs |= {chip_select_second_n === 1'h0, chip_select_first_n === 1'h0};
			if (rsp_valid === 1'h1)
				break;
		end
		n_lat = k;
		rd = rsp_rdata;
	endtask

	task automatic expect_acc(input int lat, input int strb, input int ale, input logic [1:0] c);
		check(n_lat, lat); // accept to answer
		check(n_strb, strb); // strobe width
		check(n_ale, ale); // latch width
		check(32'({bad, cs}), 32'(c)); // pins and select
	endtask

	// two requests held back to back; gap is the accept-to-accept spacing
	task automatic pair(input logic wr, output int gap);
		int k;
		@(posedge clk);
		req_valid <= 1'h1;
		req_write <= wr;
		req_addr  <= A0;
		req_wdata <= 16'h5555;
		wait_ready(k);
		wait_ready(gap);
		req_valid <= 1'h0;
		wait_ready(k);
	endtask

	initial begin
		int i, c, n, f, g;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		@(negedge clk);
		check(32'({read_strobe_n, write_strobe_n, ext_data_oe_n, address_latch}), 32'hE); // idle
		check(32'({chip_select_first_n, chip_select_second_n, rsp_valid}), 32'h6); // idle
		for (i = 0; i < 7; i++) begin
			reg_check(ofs[i], rv[i]); // reset value
			reg_write(ofs[i], 32'hFFFF_FFFF);
			reg_check(ofs[i], msk[i]); // writable bits
			reg_write(ofs[i], rv[i]);
		end
		reg_write(OFS_AREA0, 32'h6000_0000);
		reg_write(OFS_CSC0, 32'h0000_0000);
		reg_write(OFS_MODE, 32'h0000_0001);
		@(negedge clk);
		check(32'(bus_mode_separate), 32'h1); // separate mode
		for (i = 0; i < 8; i++) begin
			c = i - 4;
			n = i < 4 ? wv[i] : 0;
			f = i < 4 ? 0 : (c == 3 ? 4 : c);
			reg_write(OFS_CSC0, i < 4 ? 32'(n) : (32'(c) << RD_SETUP_LSB) | (32'(c) << WR_SETUP_LSB));
			access(1'h1, A0, 16'h1230 + 16'(i));
			expect_acc(5 + n + f, 1 + n, 0, 2'h1); // write cycle
			access(1'h0, A0, 16'h0);
			expect_acc(5 + n + f, 1 + n, 0, 2'h1); // read cycle
			check(32'(rd), 32'h1230 + 32'(i)); // read data
		end
		reg_write(OFS_CSC0, (32'h1 << RD_SETUP_LSB) | 32'h1);
		for (c = 0; c < 4; c++) begin
			f = c == 1 ? 2 : (c == 2 ? 4 : 1);
			reg_write(OFS_MODE, 32'h1 | (32'(c) << STRETCH_LSB));
			access(1'h0, A0, 16'h0);
			expect_acc(5 + 2 * f, 1 + f, 0, 2'h1); // stretched cycle
		end
		reg_write(OFS_MODE, 32'h0000_0001);
		for (c = 0; c < 12; c++) begin
			n = c < 8 ? (c == 7 ? 8 : c) : (c == 11 ? 8 : (c == 10 ? 4 : c - 7));
			if (c < 8)
				reg_write(OFS_CSC0, 32'(c) << RD_REC_LSB);
			else if (c < 11)
				reg_write(OFS_CSC0, 32'(c - 7) << SEL_REC_LSB);
			else
				reg_write(OFS_CSC0, 32'h7 << WR_REC_LSB);
			pair(c == 11, g);
			check(g, 4 + n); // recovery gap
		end
		// internal access leaves the pins alone
		access(1'h0, AI, 16'h0);
		expect_acc(1, 0, 0, 2'h0); // internal
		check(n_oe, 0); // data floated
		check(32'(ext_addr), 32'(A0[23:0])); // address held
		// multiplexed cycles at each latch delay
		reg_write(OFS_MODE, 32'h0000_0000);
		mux = 1'h1;
		@(negedge clk);
		check(32'(bus_mode_separate), 32'h0); // multiplexed mode
		for (c = 0; c < 3; c++) begin
			n = c == 2 ? 4 : c + 1;
			reg_write(OFS_CSC0, 32'(c) << LATCH_DLY_LSB);
			access(1'h1, AM, 16'hC000 + 16'(c));
			expect_acc(n + 5, 1, n, 2'h1); // latch delay
			access(1'h0, AM, 16'h0);
			expect_acc(n + 5, 1, n, 2'h1); // multiplexed cycle
			check(32'(rd), 32'hC000 + 32'(c)); // shared lines
		end
		access(1'h0, AI, 16'h0);
		expect_acc(1, 0, 0, 2'h0); // no latch pulse
		check(n_oe, 0); // lines floated
		check(32'(ext_addr[23:16]), 32'h12); // upper address held
		reg_write(OFS_MODE, 32'h0000_0001);
		mux = 1'h0;
		reg_write(OFS_CSC0, 32'h0);
		reg_write(OFS_CSC1, 32'h0);
		reg_write(OFS_AREA0, 32'h6000_0008);
		reg_write(OFS_AREA1, 32'h6010_0008);
		access(1'h0, 32'h6010_0002, 16'h0);
		expect_acc(5, 1, 0, 2'h2); // second channel
		reg_write(OFS_AREA1, 32'h6000_0008);
		access(1'h0, A0, 16'h0);
		expect_acc(5, 1, 0, 2'h1); // first wins
		print_verdict();
	end
endmodule // tb
`default_nettype wire
